// file: pkg/hspf_pkg.sv
// ==========================================================================
// Shared constants of the host serial port and its queue.
// ==========================================================================
package hspf_pkg;

    localparam int WORD_W = 8;
    localparam int ADDR_W = 5;
    localparam int CNT_W = 12;
    localparam int PTR_W = 5;
    localparam int LVL_W = 5;
    localparam int BIT_CNT_W = 3;

    localparam logic [PTR_W-1:0] QUEUE_DEPTH = 5'h18;
    localparam logic [PTR_W-1:0] QUEUE_LAST = 5'h17;

    // Word layout after the start condition.
    localparam int WORD_CMD_BIT = 7;
    localparam int WORD_READ_BIT = 6;
    localparam int WORD_CONT_BIT = 5;

    // Command codes in the low seven bits of a command word.
    localparam logic [6:0] CMD_QUEUE_CLEAR = 7'h0f;
    localparam logic [6:0] CMD_TRANSMIT = 7'h10;

    // Register addresses.
    localparam logic [ADDR_W-1:0] ADDR_QUEUE_STATUS = 5'h0c;
    localparam logic [ADDR_W-1:0] ADDR_TX_LEN_HI = 5'h1d;
    localparam logic [ADDR_W-1:0] ADDR_TX_LEN_LO = 5'h1e;
    localparam logic [ADDR_W-1:0] ADDR_QUEUE_DATA = 5'h1f;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 5'h01;

    // Queue status register fields.
    localparam int STAT_OVF_BIT = 7;
    localparam int STAT_LOW_BIT = 6;
    localparam int STAT_HIGH_BIT = 5;
    localparam int TX_LEN_HI_W = 4;

    // Occupancy thresholds for the level interrupt.
    localparam logic [CNT_W-1:0] LEVEL_LOW = 12'h006;
    localparam logic [CNT_W-1:0] LEVEL_HIGH = 12'h012;
    localparam logic [CNT_W-1:0] CNT_STEP = 12'h001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

    typedef enum logic {
        ST_WORD,
        ST_DATA
    } hspf_state_e;

endpackage

// file: core/hspf_top.sv
`timescale 1ns/1ps
module hspf_top
    import hspf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic link_sclk,
    input wire logic select_n_pin,
    input wire logic host_to_device_line,
    output logic device_to_host_line,
    output logic device_to_host_oe,
    input wire logic tx_busy,
    input wire logic rx_busy,
    input wire logic rx_valid,
    input wire logic [hspf_pkg::WORD_W-1:0] rx_data,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [hspf_pkg::WORD_W-1:0] tx_data,
    output logic tx_last,
    output logic tx_start,
    output logic queue_irq,
    output logic queue_overflow_flag,
    output logic queue_low_level_flag,
    output logic queue_high_level_flag
);
    import hspf_pkg::*;

    // ======================================================================
    // Link domain: shift in on the falling edge, out on the rising edge.
    // ======================================================================
    logic [BIT_CNT_W-1:0] bit_cnt_q;
    logic [WORD_W-2:0] shin_q;
    logic [WORD_W-1:0] word_q;
    logic word_tgl_q;
    logic [WORD_W-1:0] shout_q;
    logic dout_q;
    logic oe_q;
    logic [WORD_W-1:0] rd_byte_q;
    logic rd_mode_q;

    // Select high is the only reset of this logic, so a partial word is lost.
    always_ff @(negedge link_sclk or posedge select_n_pin) begin
        if (select_n_pin) begin
            bit_cnt_q <= '0;
            shin_q <= '0;
            word_q <= '0;
            word_tgl_q <= 1'b0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shin_q <= {shin_q[WORD_W-3:0], host_to_device_line};
            if (bit_cnt_q == 3'h7) begin
                word_q <= {shin_q, host_to_device_line};
                word_tgl_q <= ~word_tgl_q;
            end
        end
    end

    // The read byte is held steady by the system side well before the first
    // rising edge of a word, so it is sampled here as a quasi-static value.
    always_ff @(posedge link_sclk or posedge select_n_pin) begin
        if (select_n_pin) begin
            shout_q <= '0;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (bit_cnt_q == 3'h0) begin
            shout_q <= {rd_byte_q[WORD_W-2:0], 1'b0};
            dout_q <= rd_byte_q[WORD_W-1];
            oe_q <= rd_mode_q;
        end else begin
            shout_q <= {shout_q[WORD_W-2:0], 1'b0};
            dout_q <= shout_q[WORD_W-1];
        end
    end

    assign device_to_host_line = dout_q;
    assign device_to_host_oe = oe_q;

    // ======================================================================
    // Crossing into the system clock domain.
    // ======================================================================
    logic sel_m_q;
    logic sel_s_q;
    logic tgl_m_q;
    logic tgl_s_q;
    logic tgl_d_q;
    logic seen_q;

    // The toggle is cleared by select high; the extra stage keeps that clear
    // from looking like a word before the select level itself has arrived.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sel_m_q <= 1'b1;
            sel_s_q <= 1'b1;
            tgl_m_q <= 1'b0;
            tgl_s_q <= 1'b0;
            tgl_d_q <= 1'b0;
        end else if (clk_en) begin
            sel_m_q <= select_n_pin;
            sel_s_q <= sel_m_q;
            tgl_m_q <= word_tgl_q;
            tgl_s_q <= tgl_m_q;
            tgl_d_q <= tgl_s_q;
        end
    end

    logic word_evt;
    logic frame_open;
    assign frame_open = !sel_s_q;
    assign word_evt = frame_open && (tgl_d_q != seen_q);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            seen_q <= 1'b0;
        end else if (clk_en) begin
            seen_q <= frame_open ? tgl_d_q : 1'b0;
        end
    end

    // ======================================================================
    // Word decoding and transaction state.
    // ======================================================================
    hspf_state_e state_q;
    logic [ADDR_W-1:0] addr_q;
    logic rd_q;
    logic cont_q;

    logic is_cmd;
    logic [6:0] cmd_code;
    logic [ADDR_W-1:0] w_addr;
    logic w_read;
    logic w_cont;
    logic in_word;
    logic in_data;
    logic queue_single;
    assign is_cmd = word_q[WORD_CMD_BIT];
    assign cmd_code = word_q[6:0];
    assign w_read = word_q[WORD_READ_BIT];
    assign w_cont = word_q[WORD_CONT_BIT];
    assign w_addr = word_q[ADDR_W-1:0];
    assign in_word = word_evt && (state_q == ST_WORD);
    assign in_data = word_evt && (state_q == ST_DATA);
    assign queue_single = (w_addr == ADDR_QUEUE_DATA) && !w_cont;

    logic cmd_clear;
    logic cmd_tx;
    logic host_wr;
    logic host_rd;
    logic wr_len_hi;
    logic wr_len_lo;
    assign cmd_clear = in_word && is_cmd && (cmd_code == CMD_QUEUE_CLEAR);
    assign cmd_tx = in_word && is_cmd && (cmd_code == CMD_TRANSMIT);
    assign host_wr = in_data && !rd_q && (addr_q == ADDR_QUEUE_DATA);
    assign host_rd = in_data && rd_q && (addr_q == ADDR_QUEUE_DATA);
    assign wr_len_hi = in_data && !rd_q && (addr_q == ADDR_TX_LEN_HI);
    assign wr_len_lo = in_data && !rd_q && (addr_q == ADDR_TX_LEN_LO);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= ST_WORD;
            addr_q <= '0;
            rd_q <= 1'b0;
            cont_q <= 1'b0;
        end else if (clk_en) begin
            if (!frame_open) begin
                state_q <= ST_WORD;
            end else if (word_evt) begin
                case (state_q)
                    ST_WORD: begin
                        // Single-address access to the queue is refused.
                        if (!is_cmd && !queue_single) begin
                            state_q <= ST_DATA;
                            addr_q <= w_addr;
                            rd_q <= w_read;
                            cont_q <= w_cont;
                        end
                    end
                    ST_DATA: begin
                        if (!cont_q) begin
                            state_q <= ST_WORD;
                        end else if (addr_q != ADDR_QUEUE_DATA) begin
                            addr_q <= addr_q + ADDR_STEP;
                        end
                    end
                    default: begin
                        state_q <= ST_WORD;
                    end
                endcase
            end
        end
    end

    // ======================================================================
    // Queue storage, pointers and counters.
    // ======================================================================
    function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
        ptr_next = (p == QUEUE_LAST) ? '0 : p + 5'h01;
    endfunction

    logic [WORD_W-1:0] mem_q [QUEUE_DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] in_cnt_q;
    logic [CNT_W-1:0] out_cnt_q;
    logic [TX_LEN_HI_W-1:0] len_hi_q;
    logic [WORD_W-1:0] len_lo_q;

    logic [CNT_W-1:0] level;
    logic [CNT_W-1:0] tx_len;
    logic full;
    logic empty;
    logic push_req;
    logic [WORD_W-1:0] push_data;
    logic do_push;
    logic tx_take;
    logic pop_req;
    logic do_pop;
    logic ovf_evt;
    logic tx_room;
    assign level = in_cnt_q - out_cnt_q;
    assign tx_len = {len_hi_q, len_lo_q};
    assign full = (level == {7'h00, QUEUE_DEPTH});
    assign empty = (level == CNT_ZERO);
    // A host write and a received byte in the same cycle: the host wins.
    assign push_req = host_wr || rx_valid;
    assign push_data = host_wr ? word_q : rx_data;
    assign do_push = push_req && !full && !cmd_clear;
    assign ovf_evt = push_req && full;
    assign tx_room = out_cnt_q < tx_len;
    assign tx_take = tx_valid && tx_ready && !host_rd;
    assign pop_req = host_rd || tx_take;
    assign do_pop = pop_req && !empty && !cmd_clear;

    always_ff @(posedge clk) begin
        if (clk_en && do_push) begin
            mem_q[wr_ptr_q] <= push_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || (clk_en && cmd_clear)) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            in_cnt_q <= CNT_ZERO;
            out_cnt_q <= CNT_ZERO;
        end else if (clk_en) begin
            if (do_push) begin
                wr_ptr_q <= ptr_next(wr_ptr_q);
                in_cnt_q <= in_cnt_q + CNT_STEP;
            end
            if (do_pop) begin
                rd_ptr_q <= ptr_next(rd_ptr_q);
                out_cnt_q <= out_cnt_q + CNT_STEP;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            len_hi_q <= '0;
            len_lo_q <= '0;
        end else if (clk_en) begin
            if (wr_len_hi) begin
                len_hi_q <= word_q[TX_LEN_HI_W-1:0];
            end
            if (wr_len_lo) begin
                len_lo_q <= word_q;
            end
        end
    end

    // ======================================================================
    // Transmit side hand-off.
    // ======================================================================
    // Valid drops for one cycle after each take so that the head byte is
    // always registered from settled pointers; this halves peak throughput.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_valid <= 1'b0;
            tx_data <= '0;
            tx_last <= 1'b0;
            tx_start <= 1'b0;
        end else if (clk_en) begin
            tx_valid <= !empty && tx_room && !tx_take && !host_rd && !cmd_clear;
            tx_data <= mem_q[rd_ptr_q];
            tx_last <= tx_take && ((out_cnt_q + CNT_STEP) == tx_len);
            tx_start <= cmd_tx;
        end
    end

    // ======================================================================
    // Status flags, level interrupt and read data.
    // ======================================================================
    logic low_evt;
    logic high_evt;
    assign low_evt = tx_busy && (level < LEVEL_LOW);
    assign high_evt = rx_busy && (level > LEVEL_HIGH);

    // An event in the clearing cycle wins over the clear.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            queue_overflow_flag <= 1'b0;
            queue_low_level_flag <= 1'b0;
            queue_high_level_flag <= 1'b0;
            queue_irq <= 1'b0;
        end else if (clk_en) begin
            queue_overflow_flag <= ovf_evt || (queue_overflow_flag && !cmd_clear);
            queue_low_level_flag <= low_evt || (queue_low_level_flag && !cmd_clear);
            queue_high_level_flag <= high_evt || (queue_high_level_flag && !cmd_clear);
            queue_irq <= (level < LEVEL_LOW) || (level > LEVEL_HIGH);
        end
    end

    logic [WORD_W-1:0] status_byte;
    logic [WORD_W-1:0] rd_mux;
    logic rd_mapped;
    assign status_byte = {queue_overflow_flag, queue_low_level_flag,
                          queue_high_level_flag, level[LVL_W-1:0]};
    assign rd_mux = (addr_q == ADDR_QUEUE_DATA) ? mem_q[rd_ptr_q] :
                    (addr_q == ADDR_QUEUE_STATUS) ? status_byte :
                    (addr_q == ADDR_TX_LEN_HI) ? {4'h0, len_hi_q} :
                    (addr_q == ADDR_TX_LEN_LO) ? len_lo_q : 8'h00;
    assign rd_mapped = (addr_q == ADDR_QUEUE_DATA) || (addr_q == ADDR_QUEUE_STATUS) ||
                       (addr_q == ADDR_TX_LEN_HI) || (addr_q == ADDR_TX_LEN_LO);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_byte_q <= '0;
            rd_mode_q <= 1'b0;
        end else if (clk_en) begin
            rd_byte_q <= rd_mux;
            rd_mode_q <= (state_q == ST_DATA) && rd_q && rd_mapped;
        end
    end

endmodule

// file: tb/hspf_host_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Host side of the serial link.
// ==========================================================================
module hspf_host_model (
    output logic link_sclk,
    output logic select_n_pin,
    output logic host_to_device_line,
    input wire logic device_to_host_line,
    input wire logic device_to_host_oe
);
    logic [7:0] rd_word;
    event got_read;

    initial begin
        link_sclk = 1'b0;
        select_n_pin = 1'b1;
        host_to_device_line = 1'b0;
        rd_word = 8'h00;
    end

    task start_frame;
        #301.7 select_n_pin = 1'b0;
        #150;
    endtask

    task end_frame;
        #250 select_n_pin = 1'b1;
        #400;
    endtask

    // The clock stands low between words; a short bit count aborts a word.
    task xfer(input logic [7:0] w, input logic is_read, input int nbits);
        for (int i = 0; i < nbits; i++) begin
            host_to_device_line = w[7-i];
            #20 link_sclk = 1'b1;
            #32 link_sclk = 1'b0;
            // A released line is seen as the inverse of the last bit, never a fixed level.
            rd_word = {rd_word[6:0], device_to_host_oe ? device_to_host_line : ~rd_word[0]};
            #12 host_to_device_line = ~w[7-i];
        end
        #400;
        if (is_read) begin
            ->got_read;
        end
    endtask
endmodule

// file: tb/hspf_top_monitor.sv
`timescale 1ns/1ps
// ==========================================================================
// Port checker of the serial port and queue.
// ==========================================================================
module hspf_top_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic select_n_pin,
    input wire logic device_to_host_oe,
    input wire logic tx_busy,
    input wire logic rx_busy,
    input wire logic tx_ready,
    input wire logic tx_valid,
    input wire logic tx_last,
    input wire logic queue_irq,
    input wire logic queue_overflow_flag,
    input wire logic queue_low_level_flag,
    input wire logic queue_high_level_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_oe_idle; select_n_pin |-> !device_to_host_oe; endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("Output enabled while deselected.");
    property p_last_pulse; tx_last |=> !tx_last; endproperty
    a_last_pulse: assert property (p_last_pulse)
        else $error("Last-byte pulse longer than one cycle.");
    property p_last_cause; tx_last |-> $past(tx_valid) && $past(tx_ready); endproperty
    a_last_cause: assert property (p_last_cause)
        else $error("Last-byte pulse without a take.");
    property p_take_drop; tx_valid && tx_ready |=> !tx_valid; endproperty
    a_take_drop: assert property (p_take_drop)
        else $error("Valid held after a take.");
    property p_tx_stop; tx_last |-> !tx_valid [*8]; endproperty
    a_tx_stop: assert property (p_tx_stop)
        else $error("Byte offered beyond the transmit length.");
    property p_irq_reset; !$past(rst_b) |-> !queue_irq ##1 queue_irq; endproperty
    a_irq_reset: assert property (p_irq_reset)
        else $error("Empty queue does not request service after reset.");
    property p_low_cause; $rose(queue_low_level_flag) |-> $past(tx_busy); endproperty
    a_low_cause: assert property (p_low_cause)
        else $error("Low-level flag set outside transmission.");
    property p_high_cause; $rose(queue_high_level_flag) |-> $past(rx_busy); endproperty
    a_high_cause: assert property (p_high_cause)
        else $error("High-level flag set outside reception.");
    property p_ovf_cause; $rose(queue_overflow_flag) |-> $past(queue_irq); endproperty
    a_ovf_cause: assert property (p_ovf_cause)
        else $error("Overflow flag set while queue not full.");

    c_last: cover property (tx_last);
    c_ovf: cover property ($rose(queue_overflow_flag));
    c_oe: cover property (device_to_host_oe);
    c_high: cover property ($rose(queue_high_level_flag));
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench of the serial port and queue.
// ==========================================================================
module testbench;
    import hspf_pkg::*;
    logic clk, rst_b, tx_busy, rx_busy, rx_valid, tx_ready;
    logic [7:0] rx_data, tx_data;
    logic link_sclk, select_n_pin, host_to_device_line, device_to_host_line, device_to_host_oe;
    logic tx_valid, tx_last, tx_start, queue_irq;
    logic queue_overflow_flag, queue_low_level_flag, queue_high_level_flag;
    int n_fail, n_compared, cycles, seed, n_last, n_start;
    logic [7:0] exp_rd[$], exp_tx[$], qd[$], words[$];

    // Clock enable is tied on: freezing the domain is outside these scenarios.
    hspf_top i_dut (.clk(clk), .rst_b(rst_b), .clk_en(1'b1), .link_sclk(link_sclk),
        .select_n_pin(select_n_pin), .host_to_device_line(host_to_device_line),
        .device_to_host_line(device_to_host_line), .device_to_host_oe(device_to_host_oe),
        .tx_busy(tx_busy), .rx_busy(rx_busy), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_start(tx_start), .queue_irq(queue_irq), .queue_overflow_flag(queue_overflow_flag),
        .queue_low_level_flag(queue_low_level_flag),
        .queue_high_level_flag(queue_high_level_flag));
    hspf_host_model i_host (.link_sclk(link_sclk), .select_n_pin(select_n_pin),
        .host_to_device_line(host_to_device_line), .device_to_host_line(device_to_host_line),
        .device_to_host_oe(device_to_host_oe));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task close_out;
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Words from index rd_from on are read words.
    task send_frame(input int rd_from);
        i_host.start_frame();
        foreach (words[i]) i_host.xfer(words[i], i >= rd_from, 8);
        i_host.end_frame();
        words.delete();
    endtask

    task status(input logic [7:0] exp);
        words.push_back(8'h4c);
        words.push_back(8'h00);
        exp_rd.push_back(exp);
        send_frame(1);
    endtask

    always @(i_host.got_read) chk(i_host.rd_word, exp_rd.pop_front());
    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) chk(tx_data, exp_tx.pop_front());
        if (tx_last === 1'b1) n_last++;
        if (tx_start === 1'b1) n_start++;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            close_out();
        end
    end

    initial begin
        rst_b = 1'b0;
        tx_busy = 1'b0;
        rx_busy = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
        seed = $urandom(368);
        repeat (20) @(posedge clk);
        #2 rst_b = 1'b1;
        repeat (5) @(posedge clk);
        chk({7'h00, queue_irq}, 8'h01);
        status(8'h00);
        // Clear, length 20, then 25 bytes into a 24-deep queue.
        words = {8'h8f, 8'h3d, 8'h00, 8'h14};
        for (int i = 0; i < 25; i++) begin
            words.push_back(8'($urandom));
            if (i < 24) qd.push_back(words[4+i]);
        end
        send_frame(99);
        status(8'h98);
        for (int i = 0; i < 20; i++) exp_tx.push_back(qd[i]);
        words.push_back(8'h90);
        send_frame(99);
        @(posedge clk) #2 tx_busy = 1'b1;
        tx_ready = 1'b1;
        repeat (100) @(posedge clk);
        #2 tx_ready = 1'b0;
        tx_busy = 1'b0;
        chk(8'(exp_tx.size()), 8'h00);
        chk(8'(n_last), 8'h01);
        chk(8'(n_start), 8'h01);
        chk({7'h00, queue_irq}, 8'h01);
        status(8'hc4);
        words.push_back(8'h8f);
        send_frame(99);
        status(8'h00);
        qd.delete();
        @(posedge clk) #2 rx_busy = 1'b1;
        for (int i = 0; i < 19; i++) begin
            rx_data = 8'($urandom);
            qd.push_back(rx_data);
            rx_valid = 1'b1;
            @(posedge clk) #2 rx_valid = 1'b0;
            @(posedge clk) #2;
        end
        rx_busy = 1'b0;
        status(8'h33);
        words = {8'h7f, 8'h00, 8'h00};
        exp_rd.push_back(qd[0]);
        exp_rd.push_back(qd[1]);
        send_frame(1);
        // A clear command cut off after four bits must change nothing.
        i_host.start_frame();
        i_host.xfer(8'h8f, 1'b0, 4);
        i_host.end_frame();
        status(8'h31);
        chk({5'h00, queue_overflow_flag, queue_low_level_flag, queue_high_level_flag}, 8'h01);
        close_out();
    end
endmodule

bind hspf_top hspf_top_monitor i_mon (.clk(clk), .rst_b(rst_b), .select_n_pin(select_n_pin),
    .device_to_host_oe(device_to_host_oe), .tx_busy(tx_busy), .rx_busy(rx_busy),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_last(tx_last), .queue_irq(queue_irq),
    .queue_overflow_flag(queue_overflow_flag), .queue_low_level_flag(queue_low_level_flag),
    .queue_high_level_flag(queue_high_level_flag));
